// file: atss_axil_slave.sv
// AXI4-Lite slave front end: holds one write and one read, presents single-cycle strobes.
`default_nettype none
module atss_axil_slave
    import atss_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write channels
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // Read channels
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // Register strobes
    output logic                   wr_stb,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_ok,
    output logic                   rd_stb,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_ok
);
    logic              aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [3:0]        wstrb_r, wstrb_nxt;
    logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;

    assign s_awready = !aw_have_r && !bvalid_r;
    assign s_wready  = !w_have_r && !bvalid_r;
    assign s_arready = !rvalid_r;
    assign s_bvalid  = bvalid_r;
    assign s_bresp   = bresp_r;
    assign s_rvalid  = rvalid_r;
    assign s_rresp   = rresp_r;
    assign s_rdata   = rdata_r;
    assign wr_stb    = aw_have_r && w_have_r;
    assign wr_addr   = awaddr_r;
    assign wr_data   = wdata_r;
    assign wr_strb   = wstrb_r;
    assign rd_stb    = s_arvalid && s_arready;
    assign rd_addr   = s_araddr;

    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (s_awvalid && s_awready) begin
            aw_have_nxt = 1'b1;
            awaddr_nxt  = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_have_nxt = 1'b1;
            wdata_nxt  = s_wdata;
            wstrb_nxt  = s_wstrb;
        end
        if (wr_stb) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rd_stb) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_data;
            rresp_nxt  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= REG_RESET;
            wstrb_r   <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= REG_RESET;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end
endmodule // atss_axil_slave
`default_nettype wire

// file: atss_core_model.sv
// Behavioural model of the shared converter core behind the register block.
`default_nettype none
module atss_core_model
    import atss_pkg::*;
#(
    parameter int LAT = 3
) (
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // From the register block
    input wire atss_single_t          single_req,
    input wire logic [NUM_INPUTS-1:0] input_trigger,
    // Software reads of data registers
    input wire logic [NUM_INPUTS-1:0] rd_cmd,
    // To the register block
    output logic [NUM_INPUTS-1:0]     result_landed,
    output logic [NUM_INPUTS-1:0]     data_reg_read
);
    logic [NUM_INPUTS-1:0] pipe_r [LAT];
    logic [NUM_INPUTS-1:0] start;

    // Reserved selects start nothing, so a bad code never lands a result.
    always_comb begin
        start = input_trigger;
        if (single_req.req && single_req.sel_ok) begin
            start = start | (NUM_INPUTS'(1) << single_req.sel);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < LAT; i++) begin
                pipe_r[i] <= '0;
            end
            data_reg_read <= '0;
        end else begin
            pipe_r[0] <= start;
            for (int i = 1; i < LAT; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
            data_reg_read <= rd_cmd;
        end
    end

    assign result_landed = pipe_r[LAT-1];
endmodule // atss_core_model
`default_nettype wire

// file: atss_pkg.sv
// Package with register map, field layout and shared types of the converter trigger block.
// Overview of operation
// - A one written to the request bit starts a conversion of the selected input.
// - The single-input request bit clears itself on the clock cycle after it was set.
// - While the level trigger bit is one, every input whose source names it is triggered.
// - Setting the pulse trigger bit triggers every input whose source selects it.
// - The global pulse trigger bit returns to zero on the cycle after it was set.
// - Codes 0-7 select external inputs, 8-11 internal inputs; higher codes are reserved.
// - Mode bit 2n+1 selects differential conversion for input n.
// - Mode bit 2n selects signed result format for input n.
// - An interrupt enable bit lets its input's ready flag raise the shared interrupt.
// - A scan select bit includes its input in the common scan.
// - A ready flag sets when its result lands and clears when its data register is read.
// - Comparator enable bits 11:0 pass results of inputs 0 to 11 to the comparator.
`default_nettype none
package atss_pkg;
    localparam int          NUM_INPUTS    = 12;
    localparam int          SEL_W         = 6;
    localparam int          TRG_W         = 5;
    localparam int          ADDR_W        = 16;
    // Software trigger control register is placed by this block.
    localparam logic [15:0] OFS_SW_TRIG   = 16'h1430;
    localparam logic [15:0] OFS_IN_MODE   = 16'h1440;
    localparam logic [15:0] OFS_IRQ_EN    = 16'h1480;
    localparam logic [15:0] OFS_SCAN_SEL  = 16'h14a0;
    localparam logic [15:0] OFS_READY     = 16'h14c0;
    localparam logic [15:0] OFS_CMP_EN    = 16'h14e0;
    localparam int          BIT_REQ       = 8;
    localparam int          BIT_GLVL      = 7;
    localparam int          BIT_GPLS      = 6;
    localparam logic [5:0]  SEL_MAX       = 6'h0b;
    localparam logic [4:0]  TRG_NONE      = 5'h00;
    localparam logic [4:0]  TRG_GPLS      = 5'h01;
    localparam logic [4:0]  TRG_GLVL      = 5'h02;
    localparam logic [4:0]  TRG_SCAN      = 5'h03;
    localparam logic [31:0] REG_RESET     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef struct packed {
        logic [NUM_INPUTS-1:0] two_wire_input_mode;
        logic [NUM_INPUTS-1:0] sign;
        logic [NUM_INPUTS-1:0] irq_en;
        logic [NUM_INPUTS-1:0] scan;
        logic [NUM_INPUTS-1:0] cmp_en;
    } atss_cfg_t;

    typedef struct packed {
        logic             req;
        logic [SEL_W-1:0] sel;
        logic             sel_ok;
    } atss_single_t;
endpackage : atss_pkg
`default_nettype wire

// file: atss_regs.sv
// Top of the converter trigger, scan, mode and status register block.
`default_nettype none
module atss_regs
    import atss_pkg::*;
(
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0]       s_awaddr,
    input  wire logic                    s_awvalid,
    output logic                         s_awready,
    input  wire logic [31:0]             s_wdata,
    input  wire logic [3:0]              s_wstrb,
    input  wire logic                    s_wvalid,
    output logic                         s_wready,
    output logic [1:0]                   s_bresp,
    output logic                         s_bvalid,
    input  wire logic                    s_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]       s_araddr,
    input  wire logic                    s_arvalid,
    output logic                         s_arready,
    output logic [31:0]                  s_rdata,
    output logic [1:0]                   s_rresp,
    output logic                         s_rvalid,
    input  wire logic                    s_rready,
    // Trigger sources from the trigger registers
    input  wire logic [NUM_INPUTS*TRG_W-1:0] input_trigger_source,
    input  wire logic [TRG_W-1:0]        scan_trigger_source,
    // Converter core
    input  wire logic [NUM_INPUTS-1:0]   result_landed,
    input  wire logic [NUM_INPUTS-1:0]   data_reg_read,
    output atss_single_t                 single_req,
    output logic [NUM_INPUTS-1:0]        input_trigger,
    output atss_cfg_t                    cfg,
    output logic [NUM_INPUTS-1:0]        comparator_feed,
    output logic                         converter_irq
);
    logic              wr_stb, wr_ok, rd_stb, rd_ok;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0]       wr_data, rd_data;
    logic [3:0]        wr_strb;
    logic [31:0]       wmask;

    logic                  req_r, req_nxt, glvl_r, glvl_nxt, gpls_r, gpls_nxt;
    logic [SEL_W-1:0]      sel_r, sel_nxt;
    logic [2*NUM_INPUTS-1:0] mode_r, mode_nxt;
    logic [NUM_INPUTS-1:0] irq_en_r, irq_en_nxt, scan_r, scan_nxt;
    logic [NUM_INPUTS-1:0] cmp_r, cmp_nxt, rdy_r, rdy_nxt;
    logic [NUM_INPUTS-1:0] trig_raw;
    logic [31:0]           trig_reg;
    logic [31:0]           wr_merged;

    atss_axil_slave u_bus (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_stb    (wr_stb),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_ok     (wr_ok),
        .rd_stb    (rd_stb),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_ok     (rd_ok)
    );

    atss_trigger_map #(
        .N (NUM_INPUTS)
    ) u_trig (
        .glvl                 (glvl_r),
        .gpls                 (gpls_r),
        .input_trigger_source (input_trigger_source),
        .scan_trigger_source  (scan_trigger_source),
        .scan_member          (scan_r),
        .trig                 (trig_raw)
    );

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign wmask[b*8 +: 8] = {8{wr_strb[b]}};
        end
    endgenerate

    assign trig_reg = {23'h000000, req_r, glvl_r, gpls_r, sel_r};

    // Byte-lane merge against the trigger register view only; other registers are 12 or 24 bits.
    assign wr_merged = (wr_data & wmask) | (trig_reg & ~wmask);

    always_comb begin
        wr_ok = 1'b1;
        if (wr_addr == OFS_SW_TRIG) begin
            wr_ok = 1'b1;
        end else if (wr_addr == OFS_IN_MODE || wr_addr == OFS_IRQ_EN) begin
            wr_ok = 1'b1;
        end else if (wr_addr == OFS_SCAN_SEL || wr_addr == OFS_CMP_EN) begin
            wr_ok = 1'b1;
        end else if (wr_addr == OFS_READY) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = REG_RESET;
        if (rd_addr == OFS_SW_TRIG) begin
            rd_data = trig_reg;
        end else if (rd_addr == OFS_IN_MODE) begin
            rd_data = {8'h00, mode_r};
        end else if (rd_addr == OFS_IRQ_EN) begin
            rd_data = {20'h00000, irq_en_r};
        end else if (rd_addr == OFS_SCAN_SEL) begin
            rd_data = {20'h00000, scan_r};
        end else if (rd_addr == OFS_READY) begin
            rd_data = {20'h00000, rdy_r};
        end else if (rd_addr == OFS_CMP_EN) begin
            rd_data = {20'h00000, cmp_r};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_comb begin
        req_nxt    = 1'b0;
        gpls_nxt   = 1'b0;
        glvl_nxt   = glvl_r;
        sel_nxt    = sel_r;
        mode_nxt   = mode_r;
        irq_en_nxt = irq_en_r;
        scan_nxt   = scan_r;
        cmp_nxt    = cmp_r;
        // A result landing in the same cycle as its read keeps the flag set.
        rdy_nxt    = (rdy_r & ~data_reg_read) | result_landed;
        if (wr_stb) begin
            if (wr_addr == OFS_SW_TRIG) begin
                req_nxt  = wr_merged[BIT_REQ];
                glvl_nxt = wr_merged[BIT_GLVL];
                gpls_nxt = wr_merged[BIT_GPLS];
                sel_nxt  = wr_merged[SEL_W-1:0];
            end else if (wr_addr == OFS_IN_MODE) begin
                mode_nxt = (wr_data[2*NUM_INPUTS-1:0] & wmask[2*NUM_INPUTS-1:0]) |
                           (mode_r & ~wmask[2*NUM_INPUTS-1:0]);
            end else if (wr_addr == OFS_IRQ_EN) begin
                irq_en_nxt = (wr_data[NUM_INPUTS-1:0] & wmask[NUM_INPUTS-1:0]) |
                             (irq_en_r & ~wmask[NUM_INPUTS-1:0]);
            end else if (wr_addr == OFS_SCAN_SEL) begin
                scan_nxt = (wr_data[NUM_INPUTS-1:0] & wmask[NUM_INPUTS-1:0]) |
                           (scan_r & ~wmask[NUM_INPUTS-1:0]);
            end else if (wr_addr == OFS_CMP_EN) begin
                cmp_nxt = (wr_data[NUM_INPUTS-1:0] & wmask[NUM_INPUTS-1:0]) |
                          (cmp_r & ~wmask[NUM_INPUTS-1:0]);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_r    <= 1'b0;
            glvl_r   <= 1'b0;
            gpls_r   <= 1'b0;
            sel_r    <= '0;
            mode_r   <= '0;
            irq_en_r <= '0;
            scan_r   <= '0;
            cmp_r    <= '0;
            rdy_r    <= '0;
        end else begin
            req_r    <= req_nxt;
            glvl_r   <= glvl_nxt;
            gpls_r   <= gpls_nxt;
            sel_r    <= sel_nxt;
            mode_r   <= mode_nxt;
            irq_en_r <= irq_en_nxt;
            scan_r   <= scan_nxt;
            cmp_r    <= cmp_nxt;
            rdy_r    <= rdy_nxt;
        end
    end

    genvar n;
    generate
        for (n = 0; n < NUM_INPUTS; n++) begin : g_mode
            assign cfg.two_wire_input_mode[n] = mode_r[2*n+1];
            assign cfg.sign[n] = mode_r[2*n];
        end
    endgenerate

    assign cfg.irq_en = irq_en_r;
    assign cfg.scan   = scan_r;
    assign cfg.cmp_en = cmp_r;

    // Reserved select codes still reach the core on sel, but the request is raised with sel_ok low.
    assign single_req.req    = req_r;
    assign single_req.sel    = sel_r;
    assign single_req.sel_ok = (sel_r <= SEL_MAX);

    assign input_trigger   = trig_raw;
    assign comparator_feed = cmp_r & result_landed;
    assign converter_irq   = |(rdy_r & irq_en_r);
endmodule // atss_regs
`default_nettype wire

// file: atss_regs_assertions.sv
// Checker of port timing and relations for the trigger and status register block.
`default_nettype none
module atss_regs_checker
    import atss_pkg::*;
(
    // Clock and reset
    input wire logic                        aclk,
    input wire logic                        aresetn,
    // Bus responses
    input wire logic                        s_bvalid,
    input wire logic                        s_bready,
    input wire logic [1:0]                  s_bresp,
    input wire logic                        s_arvalid,
    input wire logic                        s_arready,
    input wire logic                        s_rvalid,
    input wire logic                        s_rready,
    input wire logic [31:0]                 s_rdata,
    // Converter side
    input wire logic [NUM_INPUTS*TRG_W-1:0] input_trigger_source,
    input wire logic [TRG_W-1:0]            scan_trigger_source,
    input wire logic [NUM_INPUTS-1:0]       result_landed,
    input wire atss_single_t                single_req,
    input wire logic [NUM_INPUTS-1:0]       input_trigger,
    input wire atss_cfg_t                   cfg,
    input wire logic [NUM_INPUTS-1:0]       comparator_feed,
    input wire logic                        converter_irq
);
    localparam logic [NUM_INPUTS*TRG_W-1:0] ALL_PLS = {NUM_INPUTS{TRG_GPLS}};
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_req_once; single_req.req |=> !single_req.req; endproperty
    a_req_once: assert property (p_req_once) else $error("request too long");
    property p_sel_ok; single_req.sel_ok == (single_req.sel <= SEL_MAX); endproperty
    a_sel_ok: assert property (p_sel_ok) else $error("select validity wrong");
    property p_no_src;
        (input_trigger_source == '0 && scan_trigger_source == TRG_NONE) |-> input_trigger == '0;
    endproperty
    a_no_src: assert property (p_no_src) else $error("trigger without a source");
    property p_pls;
        (input_trigger_source == ALL_PLS && scan_trigger_source == TRG_NONE && input_trigger != '0)
            |-> input_trigger == '1 ##1 input_trigger == '0;
    endproperty
    a_pls: assert property (p_pls) else $error("pulse trigger shape wrong");
    property p_irq_src; converter_irq |-> cfg.irq_en != '0; endproperty
    a_irq_src: assert property (p_irq_src) else $error("interrupt with no enable");
    property p_irq_set; (result_landed & cfg.irq_en) != '0 |=> converter_irq; endproperty
    a_irq_set: assert property (p_irq_set) else $error("ready gave no interrupt");
    property p_cmp; comparator_feed == (cfg.cmp_en & result_landed); endproperty
    a_cmp: assert property (p_cmp) else $error("comparator feed wrong");
    property p_bhold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rlat; s_arvalid && s_arready |=> s_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read data late");
    property p_rhold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");

    c_req: cover property (single_req.req);
    c_irq: cover property ($rose(converter_irq));
    c_pls: cover property (input_trigger == '1);
endmodule // atss_regs_checker

bind atss_regs atss_regs_checker chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .s_rdata(s_rdata), .input_trigger_source(input_trigger_source),
    .scan_trigger_source(scan_trigger_source), .result_landed(result_landed),
    .single_req(single_req), .input_trigger(input_trigger), .cfg(cfg),
    .comparator_feed(comparator_feed), .converter_irq(converter_irq));
`default_nettype wire

// file: atss_trigger_map.sv
// Per-input trigger decode from the software triggers and each input's trigger source.
`default_nettype none
module atss_trigger_map
    import atss_pkg::*;
#(
    parameter int N = NUM_INPUTS
) (
    // Software triggers
    input  wire logic           glvl,
    input  wire logic           gpls,
    // Per-input sources
    input  wire logic [N*TRG_W-1:0] input_trigger_source,
    input  wire logic [TRG_W-1:0]   scan_trigger_source,
    input  wire logic [N-1:0]   scan_member,
    // Result
    output logic [N-1:0]        trig
);
    logic scan_fire;

    assign scan_fire = (scan_trigger_source == TRG_GLVL && glvl) ||
                       (scan_trigger_source == TRG_GPLS && gpls);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_in
            logic [TRG_W-1:0] src;
            assign src = input_trigger_source[i*TRG_W +: TRG_W];
            assign trig[i] = (src == TRG_GLVL && glvl) ||
                             (src == TRG_GPLS && gpls) ||
                             (src == TRG_SCAN && scan_member[i] && scan_fire);
        end
    endgenerate
endmodule // atss_trigger_map
`default_nettype wire

// file: tb.sv
// Self-checking bench for the trigger, scan and status register block.
`default_nettype none
module tb
    import atss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 3;
    localparam logic [15:0] OFS [5] = '{OFS_IN_MODE, OFS_IRQ_EN, OFS_SCAN_SEL,
                                        OFS_READY, OFS_CMP_EN};
    localparam logic [31:0] MSK [5] = '{32'h00ff_ffff, 32'hfff, 32'hfff, 32'h0, 32'hfff};
    logic                    aclk = 1'b0;
    logic                    aresetn = 1'b0;
    logic [15:0]             awaddr = '0, araddr = '0;
    logic [31:0]             wdata = '0, rdata;
    logic [3:0]              wstrb = '0;
    logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                    arvalid = 1'b0, rready = 1'b0;
    logic                    awready, wready, bvalid, arready, rvalid, irq, arm = 1'b0;
    logic [1:0]              bresp, rresp;
    logic [NUM_INPUTS*TRG_W-1:0] src = '0;
    logic [TRG_W-1:0]        ssrc = '0;
    logic [NUM_INPUTS-1:0]   landed, dread, trig, feed, feed_seen, rd_cmd = '0;
    atss_single_t            sreq;
    atss_cfg_t               cfg;
    logic [5:0]              req_sel;
    logic                    req_ok;
    int                      failures = 0, samples_checked = 0, cyc = 0, req_cnt = 0, pls = 0;

    atss_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .input_trigger_source(src),
        .scan_trigger_source(ssrc), .result_landed(landed), .data_reg_read(dread),
        .single_req(sreq), .input_trigger(trig), .cfg(cfg), .comparator_feed(feed),
        .converter_irq(irq));
    atss_core_model #(.LAT(LAT)) core_u (.aclk(aclk), .aresetn(aresetn), .single_req(sreq),
        .input_trigger(trig), .rd_cmd(rd_cmd), .result_landed(landed), .data_reg_read(dread));

    always #20 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc++;
        if (sreq.req === 1'b1) begin
            req_cnt++;
            req_sel = sreq.sel;
            req_ok = sreq.sel_ok;
        end
        if (trig === 12'hfff) pls++;
        feed_seen = arm ? (feed_seen | feed) : '0;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk($sformatf("read %h", a), exp, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_SW_TRIG, 32'h0, RESP_OKAY);
        foreach (OFS[i]) rd(OFS[i], 32'h0, RESP_OKAY);
        foreach (OFS[i]) wr(OFS[i], 32'hffff_ffff, RESP_OKAY);
        foreach (OFS[i]) rd(OFS[i], MSK[i], RESP_OKAY);
        wr(OFS_IN_MODE, 32'h0080_0001, RESP_OKAY);
        chk("two wire mode", 32'h800, 32'(cfg.two_wire_input_mode));
        chk("signed format", 32'h001, 32'(cfg.sign));
        wr(16'h1450, 32'hffff_ffff, RESP_SLVERR);
        rd(16'h1450, 32'h0, RESP_SLVERR);
        $display("test register map done");
        wr(OFS_IRQ_EN, 32'h20, RESP_OKAY);
        wr(OFS_SW_TRIG, 32'h105, RESP_OKAY);
        repeat (LAT + 3) @(posedge aclk);
        chk("request count", 32'd1, 32'(req_cnt));
        chk("request select", 32'h5, 32'(req_sel));
        rd(OFS_SW_TRIG, 32'h5, RESP_OKAY);
        rd(OFS_READY, 32'h20, RESP_OKAY);
        chk("irq raised", 32'h1, 32'(irq));
        rd_cmd <= 12'h020;
        @(posedge aclk);
        rd_cmd <= '0;
        repeat (3) @(posedge aclk);
        rd(OFS_READY, 32'h0, RESP_OKAY);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(OFS_SW_TRIG, 32'h13f, RESP_OKAY);
        @(posedge aclk);
        chk("reserved select", 32'h0, 32'(req_ok));
        wr(OFS_SW_TRIG, 32'h10b, RESP_OKAY);
        repeat (LAT + 3) @(posedge aclk);
        chk("last internal select", 32'h1, 32'(req_ok));
        rd(OFS_READY, 32'h800, RESP_OKAY);
        chk("irq masked", 32'h0, 32'(irq));
        $display("test single request done");
        src <= (NUM_INPUTS*TRG_W)'(TRG_GLVL) << (3 * TRG_W);
        wr(OFS_SW_TRIG, 32'h80, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("level trigger", 32'h008, 32'(trig));
        rd(OFS_SW_TRIG, 32'h80, RESP_OKAY);
        wr(OFS_SW_TRIG, 32'h0, RESP_OKAY);
        chk("level released", 32'h0, 32'(trig));
        src <= {NUM_INPUTS{TRG_GPLS}};
        pls = 0;
        wr(OFS_SW_TRIG, 32'h40, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("pulse cycles", 32'd1, 32'(pls));
        rd(OFS_SW_TRIG, 32'h0, RESP_OKAY);
        $display("test global triggers done");
        // Scanned inputs 1 and 2 get no single request while the scan runs.
        src <= (NUM_INPUTS*TRG_W)'({TRG_SCAN, TRG_SCAN, TRG_NONE});
        ssrc <= TRG_GLVL;
        wr(OFS_SCAN_SEL, 32'h6, RESP_OKAY);
        wr(OFS_CMP_EN, 32'h2, RESP_OKAY);
        arm <= 1'b1;
        wr(OFS_SW_TRIG, 32'h80, RESP_OKAY);
        repeat (LAT + 3) @(posedge aclk);
        chk("scan trigger", 32'h006, 32'(trig));
        chk("comparator feed", 32'h002, 32'(feed_seen));
        wr(OFS_SW_TRIG, 32'h0, RESP_OKAY);
        $display("test scan done");
        test_done();
    end
endmodule // tb
`default_nettype wire
